// [old_core.sv]
// option byte loader with debugger reset request and status register
// assumes flash answers one cycle after flash_rd, cpu signals same clock
`timescale 1ns/1ns
module old_core
  import old_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sys_rst_req_n,
  input wire logic stop_recover,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic flash_rd,
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic breakpoint_exec,
  input wire logic halt_mode,
  output logic cpu_rst_n,
  output logic breakpoint_loop,
  output logic debug_halt_flag,
  output old_pkg::old_opt_t opt_cfg
);
  import old_pkg::*;

  // ==========================================================
  // reset sources
  logic [1:0] ext_sync_q;
  logic [1:0] stop_sync_q;
  logic [7:0] debugger_control_q;
  logic sys_reset_evt;
  logic [4:0] hold_cnt_q;
  old_state_t state_q;

  // two-flop synchronisers for pin level inputs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_sync_q <= 2'b11; // pin idles high, no false request
      stop_sync_q <= 2'b00;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], sys_rst_req_n};
      stop_sync_q <= {stop_sync_q[0], stop_recover};
    end
  end

  // reset event from pin, stop recovery or debugger request, the debugger request taken only while running
  assign sys_reset_evt = !ext_sync_q[1] || stop_sync_q[1] ||
                         (debugger_control_q[CTL_RST_BIT] &&
                          state_q == OLD_ST_RUN);

  // ==========================================================
  // load sequence: hold, fetch, wait, run
  // reload on a reset event seen in run; a short one in fetch or wait is dropped
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= OLD_ST_HOLD;
    else if (sys_reset_evt && state_q == OLD_ST_RUN)
      state_q <= OLD_ST_HOLD;
    else
    begin
      case (state_q)
        OLD_ST_HOLD:
          if (hold_cnt_q == 5'(RESET_HOLD_CYCLES - 1) && !sys_reset_evt)
            state_q <= OLD_ST_FETCH;
        OLD_ST_FETCH: state_q <= OLD_ST_WAIT;
        OLD_ST_WAIT: state_q <= OLD_ST_RUN;
        OLD_ST_RUN: state_q <= OLD_ST_RUN;
        default: state_q <= OLD_ST_HOLD;
      endcase
    end
  end

  // reset stretch counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_cnt_q <= 5'h00;
    else if (state_q != OLD_ST_HOLD || sys_reset_evt)
      hold_cnt_q <= 5'h00;
    else if (hold_cnt_q != 5'(RESET_HOLD_CYCLES - 1))
      hold_cnt_q <= hold_cnt_q + 5'h01;
  end

  assign flash_rd = (state_q == OLD_ST_FETCH);
  assign flash_addr = OPT_USER_ADDR; // address one never read

  // ==========================================================
  // hidden option registers
  logic [7:0] opt_raw_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      opt_raw_q <= ERASED_BYTE;
    else if (state_q == OLD_ST_WAIT)
      opt_raw_q <= flash_rdata;
  end

  always_comb
  begin
    opt_cfg.wdt_reset_mode = opt_raw_q[OPT_WDT_RESET_BIT];
    opt_cfg.wdt_auto_start = opt_raw_q[OPT_WDT_AUTO_BIT];
    opt_cfg.read_protect_active = !opt_raw_q[OPT_RPROT_BIT];
    opt_cfg.write_protect_active = !opt_raw_q[OPT_WPROT_BIT];
    opt_cfg.bod_in_stop = opt_raw_q[OPT_BOD_STOP_BIT];
    opt_cfg.osc_mode = old_osc_t'(opt_raw_q[OPT_OSC_LSB +: 2]);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cpu_rst_n <= 1'b0;
    else
      cpu_rst_n <= (state_q == OLD_ST_RUN) && !sys_reset_evt;
  end

  // ==========================================================
  // debugger control register
  logic ctrl_wr;
  logic stat_wr;

  // address match for a write strobe, shared by several processes
  function automatic logic wr_hit(input logic wr, input logic [1:0] addr,
    input logic [1:0] target);
    return wr && (addr == target);
  endfunction : wr_hit

  // write strobes per register
  assign ctrl_wr = wr_hit(reg_wr, reg_addr, ADDR_DBG_CTRL);
  assign stat_wr = wr_hit(reg_wr, reg_addr, ADDR_DBG_STAT);

  // reserved bits dropped by write mask
  // request bit clears as load ends
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      debugger_control_q <= CTL_RESET;
    else if (ctrl_wr)
      debugger_control_q <= reg_wdata & CTL_WMASK;
    else if (state_q == OLD_ST_WAIT)
      debugger_control_q[CTL_RST_BIT] <= 1'b0; // reads 1 until load done
  end
  // loop control straight from the register
  assign breakpoint_loop = debugger_control_q[CTL_BRKLOOP_BIT];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      debug_halt_flag <= 1'b0;
    else if (breakpoint_exec && !breakpoint_loop)
      debug_halt_flag <= 1'b1;
    else if (ctrl_wr)
      debug_halt_flag <= 1'b0;
  end

  // breakpoint seen since last control write, set wins
  logic breakpoint_seen_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      breakpoint_seen_q <= 1'b0;
    else if (breakpoint_exec)
      breakpoint_seen_q <= 1'b1;
    else if (ctrl_wr)
      breakpoint_seen_q <= 1'b0;
  end

  // ==========================================================
  // status and read port
  logic [7:0] status;
  always_comb
  begin
    status = 8'h00;
    status[STAT_IDLE_BIT] = debug_halt_flag || breakpoint_seen_q;
    status[STAT_HALT_BIT] = halt_mode;
    status[STAT_RP_BIT] = opt_cfg.read_protect_active;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_DBG_CTRL: reg_rdata <= debugger_control_q;
        ADDR_DBG_STAT: reg_rdata <= status;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ==========================================================
  // checks
  // cpu held loading
  a_cpu_held_loading: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q != OLD_ST_RUN) |=> !cpu_rst_n)
    else $error("cpu released before options loaded");
  a_hold_count: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_HOLD &&
    hold_cnt_q != 5'(RESET_HOLD_CYCLES - 1)) |=> state_q == OLD_ST_HOLD)
    else $error("reset hold ended early");
  a_cpu_in_reset: assert property (@(posedge core_clk)
    disable iff (!rst_n) (!ext_sync_q[1] || stop_sync_q[1]) |=>
    !cpu_rst_n)
    else $error("reset source did not hold cpu");
  a_opt_capture: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT) |=>
    opt_raw_q == $past(flash_rdata))
    else $error("option byte not captured");
  a_fetch_seq: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_FETCH) |=>
    state_q == OLD_ST_WAIT ##1 state_q == OLD_ST_RUN)
    else $error("load sequence broken");
  a_opt_stable: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_RUN && !sys_reset_evt) |=>
    $stable(opt_raw_q))
    else $error("options changed without reset");
  a_flash_addr: assert property (@(posedge core_clk)
    disable iff (!rst_n) flash_rd |-> flash_addr == OPT_USER_ADDR)
    else $error("wrong option address");
  a_flash_once: assert property (@(posedge core_clk)
    disable iff (!rst_n) flash_rd |=> !flash_rd)
    else $error("option byte read twice");
  a_wdt_mode: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT) |=>
    opt_cfg.wdt_reset_mode == $past(flash_rdata[OPT_WDT_RESET_BIT]))
    else $error("watchdog response option wrong");
  a_wdt_start: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT) |=>
    opt_cfg.wdt_auto_start == $past(flash_rdata[OPT_WDT_AUTO_BIT]))
    else $error("watchdog start option wrong");
  a_read_prot: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT) |=>
    opt_cfg.read_protect_active == !$past(flash_rdata[OPT_RPROT_BIT]))
    else $error("read protect option wrong");
  a_write_prot: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT) |=>
    opt_cfg.write_protect_active == !$past(flash_rdata[OPT_WPROT_BIT]))
    else $error("write protect option wrong");
  a_bod_stop: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT) |=>
    opt_cfg.bod_in_stop == $past(flash_rdata[OPT_BOD_STOP_BIT]))
    else $error("brownout option wrong");
  a_osc_mode: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT) |=>
    opt_cfg.osc_mode == old_osc_t'($past(flash_rdata[OPT_OSC_LSB +: 2])))
    else $error("oscillator option wrong");
  a_dbg_reset: assert property (@(posedge core_clk)
    disable iff (!rst_n) (debugger_control_q[CTL_RST_BIT] &&
    state_q == OLD_ST_RUN) |=> state_q == OLD_ST_HOLD ##1 !cpu_rst_n)
    else $error("debugger reset ignored");
  a_rst_pending: assert property (@(posedge core_clk)
    disable iff (!rst_n) (debugger_control_q[CTL_RST_BIT] && !ctrl_wr &&
    (state_q == OLD_ST_HOLD || state_q == OLD_ST_FETCH)) |=>
    debugger_control_q[CTL_RST_BIT])
    else $error("reset request cleared too early");
  a_rst_clear: assert property (@(posedge core_clk)
    disable iff (!rst_n) (state_q == OLD_ST_WAIT && !ctrl_wr) |=>
    !debugger_control_q[CTL_RST_BIT])
    else $error("reset request not cleared");
  a_ctrl_mask: assert property (@(posedge core_clk)
    disable iff (!rst_n) (debugger_control_q & ~CTL_WMASK) == 8'h00)
    else $error("reserved control bit set");
  a_bkpt_halt: assert property (@(posedge core_clk)
    disable iff (!rst_n) (breakpoint_exec && !breakpoint_loop) |=>
    debug_halt_flag)
    else $error("breakpoint did not halt");
  a_bkpt_loop: assert property (@(posedge core_clk)
    disable iff (!rst_n) (breakpoint_exec && breakpoint_loop &&
    !debug_halt_flag) |=> !debug_halt_flag)
    else $error("looping breakpoint halted");
  a_seen_set: assert property (@(posedge core_clk)
    disable iff (!rst_n) breakpoint_exec |=> breakpoint_seen_q)
    else $error("breakpoint not remembered");
  a_write_clear: assert property (@(posedge core_clk)
    disable iff (!rst_n) (ctrl_wr && !breakpoint_exec) |=>
    !breakpoint_seen_q && !debug_halt_flag)
    else $error("control write did not clear idle");
  a_idle_read: assert property (@(posedge core_clk)
    disable iff (!rst_n) (reg_rd && reg_addr == ADDR_DBG_STAT) |=>
    reg_rdata[STAT_IDLE_BIT] == $past(debug_halt_flag || breakpoint_seen_q)
    && reg_rdata[4:0] == 5'h00)
    else $error("idle or reserved status wrong");
  a_halt_read: assert property (@(posedge core_clk)
    disable iff (!rst_n) (reg_rd && reg_addr == ADDR_DBG_STAT) |=>
    reg_rdata[STAT_HALT_BIT] == $past(halt_mode))
    else $error("halt status wrong");
  a_rp_read: assert property (@(posedge core_clk)
    disable iff (!rst_n) (reg_rd && reg_addr == ADDR_DBG_STAT) |=>
    reg_rdata[STAT_RP_BIT] == !$past(opt_raw_q[OPT_RPROT_BIT]))
    else $error("read protect status wrong");
  a_hidden_read: assert property (@(posedge core_clk)
    disable iff (!rst_n) (reg_rd && reg_addr >= ADDR_OPT_RAW) |=>
    reg_rdata == 8'h00)
    else $error("hidden option register readable");
  a_stat_write: assert property (@(posedge core_clk)
    disable iff (!rst_n) (stat_wr && state_q != OLD_ST_WAIT) |=>
    $stable(debugger_control_q))
    else $error("status write changed control");
  // main scenarios reached
  c_load_done: cover property (@(posedge core_clk)
    state_q == OLD_ST_WAIT ##1 state_q == OLD_ST_RUN);
  c_dbg_reset: cover property (@(posedge core_clk)
    reg_wr && reg_addr == ADDR_DBG_CTRL && reg_wdata[CTL_RST_BIT]);
  c_bkpt_halt: cover property (@(posedge core_clk)
    breakpoint_exec && !breakpoint_loop);
  c_stat_read: cover property (@(posedge core_clk)
    reg_rd && reg_addr == ADDR_DBG_STAT);
endmodule : old_core

// [old_core_tb.sv]
// self-checking bench for the option loader and debug status block
// assumes old_flash_model stands in for the flash array
`timescale 1ns/1ns
module old_core_tb;
  import old_pkg::*;
  logic core_clk, rst_n, sys_rst_req_n, stop_recover, reg_wr, reg_rd;
  logic breakpoint_exec, halt_mode, flash_rd, cpu_rst_n, breakpoint_loop;
  logic debug_halt_flag;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, flash_rdata, user_byte, got;
  logic [15:0] flash_addr;
  old_opt_t opt_cfg;
  int failures, n_compared;
  logic [7:0] tbl [4] = '{8'hFC, 8'h01, 8'hAA, 8'h57};
  old_core old_core_i (.core_clk, .rst_n, .sys_rst_req_n, .stop_recover,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_rd,
    .flash_addr, .flash_rdata, .breakpoint_exec, .halt_mode, .cpu_rst_n,
    .breakpoint_loop, .debug_halt_flag, .opt_cfg);
  old_flash_model old_flash_model_i (.core_clk, .flash_rd, .flash_addr,
    .user_byte, .flash_rdata);
  // ==========================================================
  // helpers
  function automatic logic [7:0] exp_opt(input logic [7:0] b);
    return {1'b0, b[7], b[6], ~b[5], ~b[4], b[3], b[1:0]};
  endfunction : exp_opt
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    got = reg_rdata;
  endtask : rd
  task automatic wait_rst(input logic v);
    int k;
    for (k = 0; k < 200 && cpu_rst_n !== v; k++)
      @(negedge core_clk);
    if (cpu_rst_n !== v)
    begin
      failures++;
      wrap_up();
    end
  endtask : wait_rst
  task automatic kick(input int src);
    @(posedge core_clk);
    case (src)
      0: sys_rst_req_n <= 1'b0;
      1: stop_recover <= 1'b1;
      default: rst_n <= 1'b0;
    endcase
    repeat (4) @(posedge core_clk);
    sys_rst_req_n <= 1'b1;
    stop_recover <= 1'b0;
    rst_n <= 1'b1;
    wait_rst(1'b0);
    wait_rst(1'b1);
  endtask : kick
  task automatic fire_bkpt;
    @(posedge core_clk);
    breakpoint_exec <= 1'b1;
    @(posedge core_clk);
    breakpoint_exec <= 1'b0;
  endtask : fire_bkpt
  // ==========================================================
  // clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    wrap_up();
  end
  // ==========================================================
  // test sequence
  initial
  begin
    {rst_n, stop_recover, reg_wr, reg_rd, breakpoint_exec, halt_mode} = '0;
    sys_rst_req_n = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    user_byte = 8'h57;
    failures = 0;
    n_compared = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_rst(1'b1);
    chk({1'b0, opt_cfg}, exp_opt(8'h57));
    // new flash value must wait for a reset
    user_byte <= 8'hFC;
    repeat (8) @(posedge core_clk);
    chk({1'b0, opt_cfg}, exp_opt(8'h57));
    rd(ADDR_DBG_STAT);
    chk(got, 8'h20);
    wr(ADDR_DBG_CTRL, 8'h01);
    wait_rst(1'b0);
    wait_rst(1'b1);
    chk({1'b0, opt_cfg}, exp_opt(8'hFC));
    rd(ADDR_DBG_CTRL);
    chk(got, 8'h00);
    rd(ADDR_DBG_STAT);
    chk(got, 8'h00);
    $display("debugger reset test done");
    // pin, stop and power-on reset sources, every oscillator mode
    for (int i = 0; i < 4; i++)
    begin
      user_byte <= tbl[i];
      kick(i % 3);
      chk({1'b0, opt_cfg}, exp_opt(tbl[i]));
      rd(ADDR_DBG_STAT);
      chk(got, {2'b00, ~tbl[i][5], 5'h00});
    end
    $display("option reload test done");
    @(posedge core_clk);
    halt_mode <= 1'b1;
    rd(ADDR_DBG_STAT);
    chk(got, 8'h60);
    @(posedge core_clk);
    halt_mode <= 1'b0;
    wr(ADDR_DBG_CTRL, 8'h02);
    rd(ADDR_DBG_CTRL);
    chk(got, 8'h02);
    chk({7'h00, breakpoint_loop}, 8'h01);
    fire_bkpt();
    @(negedge core_clk);
    chk({7'h00, debug_halt_flag}, 8'h00);
    rd(ADDR_DBG_STAT);
    chk(got, 8'hA0);
    wr(ADDR_DBG_CTRL, 8'h00);
    rd(ADDR_DBG_STAT);
    chk(got, 8'h20);
    fire_bkpt();
    @(negedge core_clk);
    chk({7'h00, debug_halt_flag}, 8'h01);
    wr(ADDR_DBG_STAT, 8'hFF);
    rd(ADDR_DBG_STAT);
    chk(got, 8'hA0);
    for (int a = 2; a < 4; a++)
    begin
      rd(a[1:0]);
      chk(got, 8'h00);
    end
    $display("status register test done");
    wrap_up();
  end
endmodule : old_core_tb

// [old_flash_model.sv]
// flash array model holding the two option bytes
// assumes the loader reads one byte per flash_rd pulse
`timescale 1ns/1ns
module old_flash_model (
  input wire logic core_clk,
  input wire logic flash_rd,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] user_byte,
  output logic [7:0] flash_rdata
);
  import old_pkg::*;
  // ==========================================================
  // read port
  initial flash_rdata = 8'h5A;
  // answer the cycle after a read, garbage otherwise
  always @(posedge core_clk)
  begin
    if (flash_rd)
      flash_rdata <= (flash_addr == OPT_USER_ADDR) ? user_byte : ERASED_BYTE;
    else
      flash_rdata <= ~flash_rdata; // no stale value left on the bus
  end
endmodule : old_flash_model

// [old_pkg.sv]
// package for the option loader and debug status block
// assumes one 20 MHz core clock and an active-low asynchronous reset
package old_pkg;
  // ==========================================================
  // flash and register map
  localparam logic [15:0] OPT_USER_ADDR = 16'h0000; // user option byte
  localparam logic [15:0] OPT_RSVD_ADDR = 16'h0001; // kept erased
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] ADDR_DBG_CTRL = 2'h0;
  localparam logic [1:0] ADDR_DBG_STAT = 2'h1;
  localparam logic [1:0] ADDR_OPT_RAW = 2'h2;
  // ==========================================================
  // option byte fields
  localparam int OPT_WDT_RESET_BIT = 7; // 1 = time-out resets
  localparam int OPT_WDT_AUTO_BIT = 6;  // 1 = running at reset
  localparam int OPT_RPROT_BIT = 5;     // 0 = read protect on
  localparam int OPT_WPROT_BIT = 4;     // 0 = write protect on
  localparam int OPT_BOD_STOP_BIT = 3;  // 1 = kept on in deep sleep
  localparam int OPT_OSC_LSB = 0;       // two-bit oscillator mode
  // ==========================================================
  // debugger control and status fields
  localparam int CTL_RST_BIT = 0;
  localparam int CTL_BRKLOOP_BIT = 1;
  localparam int STAT_IDLE_BIT = 7;
  localparam int STAT_HALT_BIT = 6;
  localparam int STAT_RP_BIT = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'h03;
  localparam int RESET_HOLD_CYCLES = 16; // system reset stretch
  typedef enum logic [1:0] {
    OLD_OSC_HIGH = 2'h0, OLD_OSC_MED = 2'h1,
    OLD_OSC_LOW = 2'h2, OLD_OSC_RC = 2'h3
  } old_osc_t;
  typedef struct packed {
    logic wdt_reset_mode;
    logic wdt_auto_start;
    logic read_protect_active;
    logic write_protect_active;
    logic bod_in_stop;
    old_osc_t osc_mode;
  } old_opt_t;
  typedef enum logic [1:0] {
    OLD_ST_HOLD = 2'b00, OLD_ST_FETCH = 2'b01,
    OLD_ST_WAIT = 2'b11, OLD_ST_RUN = 2'b10
  } old_state_t;
endpackage : old_pkg
